/* File: design/mas_axis_map.svh */
// Register offsets, field positions, reset values and sizes of the axis selector
`ifndef MAS_AXIS_MAP_SVH
`define MAS_AXIS_MAP_SVH
`define MAS_NAXES 14
`define MAS_ADDR_W 8
`define MAS_OFF_CTRL 8'h00
`define MAS_OFF_PLUS 8'h04
`define MAS_OFF_MINUS 8'h08
`define MAS_OFF_MAE 8'h0C
`define MAS_OFF_REM 8'h10
`define MAS_OFF_ACMD 8'h14
`define MAS_OFF_MILK 8'h18
`define MAS_OFF_AILK 8'h1C
`define MAS_OFF_LIM 8'h20
`define MAS_OFF_OVR 8'h24
`define MAS_OFF_AFEED 8'h28
`define MAS_OFF_MFEED 8'h2C
`define MAS_OFF_CMD 8'h30
`define MAS_OFF_STAT 8'h34
`define MAS_OFF_MOTION 8'h38
`define MAS_CTRL_AUTO 0
`define MAS_CTRL_JOG 1
`define MAS_CTRL_INCR 2
`define MAS_CTRL_REFRET 3
`define MAS_CTRL_HANDLE 4
`define MAS_CTRL_MCUT 5
`define MAS_CTRL_ARAPID 6
`define MAS_CTRL_SBLK 7
`define MAS_CTRL_HOLD 8
`define MAS_CTRL_ERRCLR 9
`define MAS_CTRL_MRAPID 10
`define MAS_CTRL_W 11
`define MAS_CMD_SET 8
`define MAS_CMD_MOVE 9
`define MAS_OVR_CANCEL 24
`define MAS_OVR_100 8'h64
`define MAS_OVR_RST 32'h00646464
`endif

/* File: design/mas_axis_select.sv */
// Manual/automatic axis selection core with APB register slave
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mas_axis_map.svh"
// Operation
// RL1: Minus feed select moves its axis negative in jog, incremental, return modes.
// RL2: Simultaneous mode only when automatic and manual modes are both selected.
// RL3: In simultaneous mode, marked axes alone accept manual motion during automatic.
// RL4: Automatic command to marked axis raises error, interlocks automatic until cleared.
// RL5: Pure automatic mode ignores manual-in-auto bits and adds no interlock; the core still errors on a move command to a marked axis (g53_err).
// RL6: Mark rising on automatically moving axis stops it and raises the error.
// RL7: Manual commands rejected on unmarked axes; handle interruption still allowed.
// RL8: Feedrates and acceleration modes kept separate for automatic and manual groups.
// RL9: Rapid override both groups; cutting overrides manual only if enabled; cancel automatic.
// RL10: Manual interlocks gate manual axes, automatic interlocks gate automatic axes.
// RL11: Cutting and rapid status follow the automatic axes only.
// RL12: Single block stop and feed hold never stop manual motion.
// RL13: Coordinate commands on marked axes wait for manual stop; moves then error.
// RL14: Limit trip on manual axis in simultaneous mode holds automatic axes.
// RL15: Handle interruption on unmarked axes acts on automatic motion; marked stay manual.
// RL16: Axis removal bit excludes its axis from control, one bit per axis.
// RL17: Removed axis loses position control, counts as interlocked, stays displayed.
// RL18: Plus and minus together select no direction.
// RL19: Feed select raised before its mode must be dropped and raised again.
// RL20: Selection bits are sampled once per scan; edges compare consecutive scans.
module mas_axis_select
   import mas_pkg::*;
#(
   parameter int NAX = `MAS_NAXES
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic SCAN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [`MAS_ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic [NAX-1:0] MAN_PLUS_O,
   output logic [NAX-1:0] MAN_MINUS_O,
   output logic [NAX-1:0] AUTO_EN_O,
   output logic [NAX-1:0] HANDLE_INT_O,
   output logic [NAX-1:0] POS_CTRL_O,
   output logic [NAX-1:0] AXIS_ILK_O,
   output logic SIMUL_O,
   output logic OP_ERR_O,
   output logic AUTO_ILK_O,
   output logic FEED_HOLD_O,
   output logic IN_CUT_O,
   output logic IN_RAPID_O,
   output logic COORD_EXEC_O,
   output mas_ovr_pair_t OVR_O,
   output logic [15:0] AUTO_FEED_O,
   output logic [15:0] MAN_FEED_O,
   output logic AUTO_ACC_O,
   output logic MAN_ACC_O
);
   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [`MAS_CTRL_W-1:0] r_ctrl;
   logic [NAX-1:0] r_plus, r_minus, r_mae, r_rem, r_acmd, r_milk, r_ailk;
   logic [NAX-1:0] r_lim;
   logic [31:0] r_ovr;
   logic [15:0] r_afeed, r_mfeed;
   logic [3:0] cmd_ax;
   logic cmd_set, cmd_mv;
   logic wr_en, rd_en, hit, err_clr, cmd_wr;
   logic [31:0] next_rdata;
   mas_cmd_st_t cmd_st;
   logic err, hold_l;

   // Access completes in the second access cycle
   assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
   assign rd_en = PSEL_I & PENABLE_I & ~PWRITE_I & ~PREADY_O;
   assign err_clr = wr_en & (PADDR_I == `MAS_OFF_CTRL)
                    & PWDATA_I[`MAS_CTRL_ERRCLR];
   assign cmd_wr = wr_en & (PADDR_I == `MAS_OFF_CMD)
                   & (PWDATA_I[`MAS_CMD_SET] | PWDATA_I[`MAS_CMD_MOVE]);

   function automatic logic [31:0] zx(input logic [NAX-1:0] v);
      return {{(32-NAX){1'b0}}, v};
   endfunction

   always_comb begin
      hit = 1'b1;
      next_rdata = 32'h00000000;
      case (PADDR_I)
         `MAS_OFF_CTRL: next_rdata = {21'h000000, r_ctrl};
         `MAS_OFF_PLUS: next_rdata = zx(r_plus);
         `MAS_OFF_MINUS: next_rdata = zx(r_minus);
         `MAS_OFF_MAE: next_rdata = zx(r_mae);
         `MAS_OFF_REM: next_rdata = zx(r_rem);
         `MAS_OFF_ACMD: next_rdata = zx(r_acmd);
         `MAS_OFF_MILK: next_rdata = zx(r_milk);
         `MAS_OFF_AILK: next_rdata = zx(r_ailk);
         `MAS_OFF_LIM: next_rdata = zx(r_lim);
         `MAS_OFF_OVR: next_rdata = r_ovr;
         `MAS_OFF_AFEED: next_rdata = {16'h0000, r_afeed};
         `MAS_OFF_MFEED: next_rdata = {16'h0000, r_mfeed};
         `MAS_OFF_CMD: next_rdata = {22'h000000, cmd_mv, cmd_set,
                                     4'h0, cmd_ax};
         `MAS_OFF_STAT: next_rdata = {28'h0000000, (cmd_st == CMD_WAIT),
                                      hold_l, err, SIMUL_O};
         `MAS_OFF_MOTION: next_rdata = zx(MAN_PLUS_O | MAN_MINUS_O);
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         PREADY_O <= 1'b0;
         PRDATA_O <= 32'h00000000;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
         PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~hit;
         if (rd_en) begin
            PRDATA_O <= next_rdata;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         r_ctrl <= '0;
         {r_plus, r_minus, r_mae, r_rem, r_acmd, r_lim} <= '0;
         // Interlocks are break contacts: one means free to move
         r_milk <= '1;
         r_ailk <= '1;
         r_ovr <= `MAS_OVR_RST;
         r_afeed <= 16'h0000;
         r_mfeed <= 16'h0000;
         {cmd_ax, cmd_set, cmd_mv} <= '0;
      end else if (wr_en) begin
         case (PADDR_I)
            `MAS_OFF_CTRL: begin
               r_ctrl <= PWDATA_I[`MAS_CTRL_W-1:0];
               // Clear strobe never stays stored
               r_ctrl[`MAS_CTRL_ERRCLR] <= 1'b0;
            end
            `MAS_OFF_PLUS: r_plus <= PWDATA_I[NAX-1:0];
            `MAS_OFF_MINUS: r_minus <= PWDATA_I[NAX-1:0];
            `MAS_OFF_MAE: r_mae <= PWDATA_I[NAX-1:0];
            `MAS_OFF_REM: r_rem <= PWDATA_I[NAX-1:0];
            `MAS_OFF_ACMD: r_acmd <= PWDATA_I[NAX-1:0];
            `MAS_OFF_MILK: r_milk <= PWDATA_I[NAX-1:0];
            `MAS_OFF_AILK: r_ailk <= PWDATA_I[NAX-1:0];
            `MAS_OFF_LIM: r_lim <= PWDATA_I[NAX-1:0];
            `MAS_OFF_OVR: r_ovr <= {7'h00, PWDATA_I[24:0]};
            `MAS_OFF_AFEED: r_afeed <= PWDATA_I[15:0];
            `MAS_OFF_MFEED: r_mfeed <= PWDATA_I[15:0];
            `MAS_OFF_CMD: begin
               if (cmd_st == CMD_IDLE) begin
                  cmd_ax <= PWDATA_I[3:0];
                  cmd_set <= PWDATA_I[`MAS_CMD_SET];
                  cmd_mv <= PWDATA_I[`MAS_CMD_MOVE];
               end
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Scan sampling
   // ----------------------------------------------------------------
   logic [NAX-1:0] s_plus, s_minus, s_mae, s_rem, s_acmd, s_lim;
   logic [NAX-1:0] p_plus, p_minus, p_mae, p_acmd;
   logic [4:0] s_mode;
   logic scan_d;

   // Levels change only at scan so the core sees a coherent snapshot
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         {s_plus, s_minus, s_mae, s_rem, s_acmd, s_lim} <= '0;
         {p_plus, p_minus, p_mae, p_acmd} <= '0;
         s_mode <= 5'h00;
         scan_d <= 1'b0;
      end else begin
         scan_d <= SCAN_I;
         if (SCAN_I) begin // [RL20]
            {p_plus, p_minus, p_mae, p_acmd} <=
               {s_plus, s_minus, s_mae, s_acmd};
            {s_plus, s_minus, s_mae, s_rem} <= {r_plus, r_minus, r_mae, r_rem};
            {s_acmd, s_lim} <= {r_acmd, r_lim};
            s_mode <= r_ctrl[`MAS_CTRL_HANDLE:`MAS_CTRL_AUTO];
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode decode and events
   // ----------------------------------------------------------------
   logic auto_m, feed_m, man_m, simul_c;
   logic [NAX-1:0] man_ok, man_mv, rise_mae, rise_acmd, stp;
   logic ev_err, ev_lim, g53_err, stop_ok, ax_mae, ax_mv;

   assign auto_m = s_mode[`MAS_CTRL_AUTO];
   assign feed_m = s_mode[`MAS_CTRL_JOG] | s_mode[`MAS_CTRL_INCR]
                   | s_mode[`MAS_CTRL_REFRET];
   assign man_m = feed_m | s_mode[`MAS_CTRL_HANDLE];
   assign simul_c = auto_m & man_m; // [RL2]
   assign man_mv = MAN_PLUS_O | MAN_MINUS_O;
   assign rise_mae = s_mae & ~p_mae & {NAX{scan_d}};
   assign rise_acmd = s_acmd & ~p_acmd & {NAX{scan_d}};
   // Outside simultaneous mode the mark bits count only in the coordinate move error (g53_err)
   assign ev_err = simul_c & (|((rise_acmd & s_mae) | (rise_mae & s_acmd)))
                   | g53_err; // [RL4] [RL5] [RL6]
   assign ev_lim = scan_d & simul_c & (|(s_lim & s_mae)); // [RL14]
   // Manual requests pass only on marked axes while automatic is on
   assign man_ok = ~s_rem & r_milk
                   & (auto_m ? s_mae : {NAX{1'b1}}); // [RL3] [RL7] [RL10]

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         err <= 1'b0;
      end else if (ev_err) begin
         err <= 1'b1; // [RL4]
      end else if (err_clr) begin
         err <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         hold_l <= 1'b0;
      end else if (ev_lim) begin
         hold_l <= 1'b1; // [RL14]
      end else if (err_clr) begin
         hold_l <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Coordinate command deferral
   // ----------------------------------------------------------------
   assign ax_mae = (cmd_ax < 4'(NAX)) ? s_mae[cmd_ax] : 1'b0;
   assign ax_mv = (cmd_ax < 4'(NAX)) ? man_mv[cmd_ax] : 1'b0;
   assign stop_ok = ~(ax_mae & ax_mv); // [RL13]
   assign g53_err = (cmd_st == CMD_WAIT) & stop_ok & cmd_mv & ax_mae;

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         cmd_st <= CMD_IDLE;
         COORD_EXEC_O <= 1'b0;
      end else begin
         COORD_EXEC_O <= 1'b0;
         case (cmd_st)
            CMD_IDLE: if (cmd_wr) cmd_st <= CMD_WAIT;
            CMD_WAIT: begin
               if (stop_ok) begin // [RL13]
                  COORD_EXEC_O <= ~g53_err;
                  cmd_st <= CMD_IDLE;
               end
            end
            default: cmd_st <= CMD_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Per-axis motion gating
   // ----------------------------------------------------------------
   logic auto_hold, sblk;
   assign sblk = r_ctrl[`MAS_CTRL_SBLK];
   assign auto_hold = hold_l | r_ctrl[`MAS_CTRL_HOLD];

   for (genvar i = 0; i < NAX; i++) begin : g_ax
      logic arm_p, arm_m;

      // Arming only on a rise seen while a feed mode stands
      always_ff @(posedge CLK_I) begin
         if (RST_I || !feed_m) begin
            arm_p <= 1'b0;
            arm_m <= 1'b0;
         end else begin
            if (scan_d && s_plus[i] && !p_plus[i]) arm_p <= 1'b1; // [RL19]
            else if (!s_plus[i]) arm_p <= 1'b0;
            if (scan_d && s_minus[i] && !p_minus[i]) arm_m <= 1'b1; // [RL19]
            else if (!s_minus[i]) arm_m <= 1'b0;
         end
      end

      // Stop latch for an axis taken over while moving automatically
      always_ff @(posedge CLK_I) begin
         if (RST_I) begin
            stp[i] <= 1'b0;
         end else if (simul_c && rise_mae[i] && s_acmd[i]) begin
            stp[i] <= 1'b1; // [RL6]
         end else if (!s_mae[i] || !s_acmd[i]) begin
            stp[i] <= 1'b0;
         end
      end

      // Feed hold and single block leave manual motion alone
      always_ff @(posedge CLK_I) begin
         if (RST_I) begin
            MAN_PLUS_O[i] <= 1'b0;
            MAN_MINUS_O[i] <= 1'b0;
         end else begin
            MAN_PLUS_O[i] <= man_ok[i] & arm_p & s_plus[i]
                             & ~s_minus[i]; // [RL18] [RL12]
            MAN_MINUS_O[i] <= man_ok[i] & arm_m & s_minus[i]
                              & ~s_plus[i]; // [RL1] [RL18]
         end
      end

      always_ff @(posedge CLK_I) begin
         if (RST_I) begin
            AUTO_EN_O[i] <= 1'b0;
            HANDLE_INT_O[i] <= 1'b0;
            POS_CTRL_O[i] <= 1'b0;
            AXIS_ILK_O[i] <= 1'b0;
         end else begin
            AUTO_EN_O[i] <= s_acmd[i] & r_ailk[i] & ~s_rem[i] & ~err
                            & ~auto_hold & ~sblk & ~stp[i]
                            & ~(simul_c & s_mae[i]); // [RL10] [RL3] [RL14]
            HANDLE_INT_O[i] <= simul_c & ~s_mae[i] & s_acmd[i]; // [RL15]
            POS_CTRL_O[i] <= ~s_rem[i]; // [RL16] [RL17]
            AXIS_ILK_O[i] <= s_rem[i]; // [RL17]
         end
      end
   end

   // ----------------------------------------------------------------
   // Status, overrides and feed outputs
   // ----------------------------------------------------------------
   logic ovr_cancel;
   assign ovr_cancel = r_ovr[`MAS_OVR_CANCEL];

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         {SIMUL_O, OP_ERR_O, AUTO_ILK_O, FEED_HOLD_O} <= 4'h0;
         {IN_CUT_O, IN_RAPID_O, AUTO_ACC_O, MAN_ACC_O} <= 4'h0;
         OVR_O <= '0;
         AUTO_FEED_O <= 16'h0000;
         MAN_FEED_O <= 16'h0000;
      end else begin
         SIMUL_O <= simul_c; // [RL2]
         OP_ERR_O <= err;
         AUTO_ILK_O <= err; // [RL4]
         FEED_HOLD_O <= auto_hold; // [RL14]
         IN_CUT_O <= (|AUTO_EN_O) & ~r_ctrl[`MAS_CTRL_ARAPID]; // [RL11]
         IN_RAPID_O <= (|AUTO_EN_O) & r_ctrl[`MAS_CTRL_ARAPID]; // [RL11]
         AUTO_ACC_O <= r_ctrl[`MAS_CTRL_ARAPID]; // [RL8]
         MAN_ACC_O <= r_ctrl[`MAS_CTRL_MRAPID]; // [RL8]
         AUTO_FEED_O <= r_afeed; // [RL8]
         MAN_FEED_O <= r_mfeed;
         OVR_O.auto_g.rapid <= r_ovr[7:0]; // [RL9]
         OVR_O.man_g.rapid <= r_ovr[7:0];
         OVR_O.auto_g.cut <= ovr_cancel ? `MAS_OVR_100 : r_ovr[15:8];
         OVR_O.auto_g.cut2 <= ovr_cancel ? `MAS_OVR_100 : r_ovr[23:16];
         OVR_O.man_g.cut <= r_ctrl[`MAS_CTRL_MCUT] ? r_ovr[15:8]
                                                   : `MAS_OVR_100; // [RL9]
         OVR_O.man_g.cut2 <= r_ctrl[`MAS_CTRL_MCUT] ? r_ovr[23:16]
                                                    : `MAS_OVR_100;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   sequence lim_hit_s;
      ev_lim;
   endsequence
   sequence held_s;
      FEED_HOLD_O && (AUTO_EN_O == '0);
   endsequence
   sequence apb_acc_s;
      PSEL_I && PENABLE_I && !PREADY_O;
   endsequence

   simul_mode_a: assert property (SIMUL_O |-> // [RL2]
      $past(auto_m) && $past(man_m))
      else $error("simultaneous mode without both modes");
   err_set_a: assert property (ev_err |=> // [RL4]
      ##1 (OP_ERR_O && AUTO_ILK_O))
      else $error("error or interlock missing after event");
   auto_lock_a: assert property (OP_ERR_O |-> AUTO_EN_O == '0) // [RL4]
      else $error("automatic axis enabled during error");
   pure_auto_a: assert property (!simul_c && !g53_err |=> !$rose(err)) // [RL5]
      else $error("error raised outside simultaneous mode");
   dir_excl_a: assert property ((MAN_PLUS_O & MAN_MINUS_O) == '0) // [RL18]
      else $error("both directions driven");
   // Outputs still hold reset values one edge after release
   removal_a: assert property (!$past(RST_I) |-> // [RL17]
      (($past(s_rem) & (man_mv | AUTO_EN_O)) == '0)
      && (POS_CTRL_O == ~$past(s_rem)))
      else $error("removed axis still controlled");
   man_gate_a: assert property ((man_mv & ~$past(man_ok)) == '0) // [RL7]
      else $error("manual motion on a rejected axis");
   hold_auto_a: assert property (lim_hit_s |=> ##1 held_s) // [RL14]
      else $error("limit trip did not hold automatic axes");
   cmd_defer_a: assert property (cmd_st == CMD_WAIT && !stop_ok
      |=> cmd_st == CMD_WAIT && !COORD_EXEC_O) // [RL13]
      else $error("coordinate command ran during manual motion");
   apb_ans_a: assert property (apb_acc_s |=> PREADY_O)
      else $error("no ready one cycle into access");
endmodule
`default_nettype wire

/* File: design/mas_pkg.sv */
// Types shared by the axis selector
package mas_pkg;
   typedef struct packed {
      logic [7:0] rapid;
      logic [7:0] cut;
      logic [7:0] cut2;
   } mas_ovr_t;
   typedef struct packed {
      mas_ovr_t auto_g;
      mas_ovr_t man_g;
   } mas_ovr_pair_t;
   typedef enum logic [0:0] {
      CMD_IDLE = 1'b0,
      CMD_WAIT = 1'b1
   } mas_cmd_st_t;
endpackage

/* File: sim/mas_axis_select_bench.sv */
// Self-checking bench for the manual/automatic axis selector
`timescale 1ns/1ps
`default_nettype none
`include "mas_axis_map.svh"
module mas_axis_select_bench;
   localparam int NAX = `MAS_NAXES;
   localparam logic [31:0] ALL = (32'h1 << NAX) - 32'h1;
   localparam logic [31:0] A = 32'h1 << `MAS_CTRL_AUTO;
   localparam logic [31:0] J = 32'h1 << `MAS_CTRL_JOG;
   localparam logic [31:0] CLR = 32'h1 << `MAS_CTRL_ERRCLR;
   logic clk, rst, scan, psel, pen, pwr, pready, pslverr, last_err;
   logic simul, op_err, auto_ilk, feed_hold, coord_exec, aacc, macc;
   logic in_cut, in_rapid;
   logic [`MAS_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [NAX-1:0] man_plus, man_minus, auto_en, pos_ctrl, axis_ilk, hint;
   logic [47:0] ovr;
   logic [15:0] afeed, mfeed;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   mas_axis_select #(.NAX(NAX)) DUT (.CLK_I(clk), .RST_I(rst),
      .SCAN_I(scan), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .MAN_PLUS_O(man_plus),
      .MAN_MINUS_O(man_minus), .AUTO_EN_O(auto_en), .HANDLE_INT_O(hint),
      .POS_CTRL_O(pos_ctrl), .AXIS_ILK_O(axis_ilk), .SIMUL_O(simul),
      .OP_ERR_O(op_err), .AUTO_ILK_O(auto_ilk), .FEED_HOLD_O(feed_hold),
      .IN_CUT_O(in_cut), .IN_RAPID_O(in_rapid),
      .COORD_EXEC_O(coord_exec), .OVR_O(ovr),
      .AUTO_FEED_O(afeed), .MAN_FEED_O(mfeed), .AUTO_ACC_O(aacc),
      .MAN_ACC_O(macc));
   mas_ladder_model #(.SCAN_PER(8)) LAD (.clk_i(clk), .rst_i(rst),
      .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
      .scan_o(scan), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
      .paddr_o(paddr), .pwdata_o(pwdata));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Whole run needs about six hundred cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      LAD.xfer(1'b1, a, d, r, last_err);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      LAD.xfer(1'b0, a, 32'h0, r, last_err);
   endtask
   // Two scan strobes pass, then the scan+2 update settles
   task automatic sync();
      repeat (2) begin
         @(posedge clk);
         while (scan !== 1'b1) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
   function automatic logic [47:0] exp_ovr(input logic [31:0] v,
         input logic mc);
      logic [23:0] a;
      a = {v[7:0], v[15:8], v[23:16]};
      if (v[`MAS_OVR_CANCEL]) a[15:0] = {`MAS_OVR_100, `MAS_OVR_100};
      return {a, v[7:0], mc ? v[15:8] : `MAS_OVR_100,
              mc ? v[23:16] : `MAS_OVR_100};
   endfunction
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int k;
      logic [31:0] r, m, ov;
      logic [47:0] e;
      logic seen;
      rst = 1'b1;
      void'($urandom(32'h6e94f616));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      k = $urandom % NAX;
      m = 32'h1 << k;
      rd(`MAS_OFF_MILK, r);
      chk(r, ALL);
      rd(`MAS_OFF_OVR, r);
      chk(r, `MAS_OVR_RST);
      rd(8'hFC, r);
      chk({r, last_err}, 33'h1);
      $display("test reset done");
      // Feed select raised before jog mode is ignored
      wr(`MAS_OFF_MINUS, m);
      sync();
      wr(`MAS_OFF_CTRL, J);
      sync();
      chk({simul, man_minus}, 0);
      wr(`MAS_OFF_MINUS, 0);
      sync();
      wr(`MAS_OFF_MINUS, m);
      sync();
      chk(man_minus, m[NAX-1:0]);
      wr(`MAS_OFF_PLUS, m);
      sync();
      chk({man_plus, man_minus}, 0);
      wr(`MAS_OFF_PLUS, 0);
      wr(`MAS_OFF_MINUS, 0);
      $display("test jog done");
      wr(`MAS_OFF_CTRL, A | J);
      sync();
      chk(simul, 1);
      wr(`MAS_OFF_MINUS, m);
      sync();
      chk(man_minus, 0);
      wr(`MAS_OFF_MINUS, 0);
      wr(`MAS_OFF_MAE, m);
      sync();
      wr(`MAS_OFF_MINUS, m);
      sync();
      chk(man_minus, m[NAX-1:0]);
      wr(`MAS_OFF_CTRL, A | J | (32'h1 << `MAS_CTRL_HOLD));
      repeat (3) @(posedge clk);
      chk(man_minus, m[NAX-1:0]);
      wr(`MAS_OFF_MILK, ALL & ~m);
      repeat (3) @(posedge clk);
      chk(man_minus, 0);
      wr(`MAS_OFF_MILK, ALL);
      wr(`MAS_OFF_MINUS, 0);
      wr(`MAS_OFF_CTRL, A | J);
      $display("test simultaneous done");
      wr(`MAS_OFF_ACMD, m);
      sync();
      chk({op_err, auto_ilk, auto_en[k]}, 3'b110);
      wr(`MAS_OFF_ACMD, 0);
      wr(`MAS_OFF_CTRL, A | J | CLR);
      sync();
      chk({op_err, auto_ilk}, 0);
      wr(`MAS_OFF_MAE, 0);
      sync();
      wr(`MAS_OFF_ACMD, m);
      sync();
      chk({op_err, auto_en[k]}, 2'b01);
      chk({in_cut, in_rapid, hint[k]}, 3'b101);
      wr(`MAS_OFF_MAE, m);
      sync();
      chk({op_err, auto_en[k]}, 2'b10);
      wr(`MAS_OFF_ACMD, 0);
      wr(`MAS_OFF_CTRL, A | J | CLR);
      wr(`MAS_OFF_LIM, m);
      sync();
      chk(feed_hold, 1);
      wr(`MAS_OFF_LIM, 0);
      wr(`MAS_OFF_CTRL, A | CLR);
      sync();
      wr(`MAS_OFF_ACMD, m);
      sync();
      chk({simul, op_err, auto_ilk, feed_hold}, 0);
      wr(`MAS_OFF_ACMD, 0);
      wr(`MAS_OFF_MAE, 0);
      $display("test errors done");
      wr(`MAS_OFF_REM, m);
      sync();
      chk({pos_ctrl, axis_ilk}, {~m[NAX-1:0], m[NAX-1:0]});
      wr(`MAS_OFF_REM, 0);
      r = $urandom;
      wr(`MAS_OFF_AFEED, r);
      wr(`MAS_OFF_MFEED, ~r);
      wr(`MAS_OFF_CTRL, 32'h1 << `MAS_CTRL_ARAPID);
      repeat (3) @(posedge clk);
      chk({afeed, mfeed, aacc, macc}, {r[15:0], ~r[15:0], 2'b10});
      ov = $urandom & 32'h00FFFFFF;
      wr(`MAS_OFF_OVR, ov);
      wr(`MAS_OFF_CTRL, 0);
      repeat (3) @(posedge clk);
      chk(ovr, exp_ovr(ov, 1'b0));
      wr(`MAS_OFF_CTRL, 32'h1 << `MAS_CTRL_MCUT);
      repeat (3) @(posedge clk);
      chk(ovr, exp_ovr(ov, 1'b1));
      ov = ov | (32'h1 << `MAS_OVR_CANCEL);
      wr(`MAS_OFF_OVR, ov);
      repeat (3) @(posedge clk);
      e = exp_ovr(ov, 1'b1);
      chk(ovr, e);
      $display("test overrides done");
      seen = 1'b0;
      wr(`MAS_OFF_CMD, (32'h1 << `MAS_CMD_SET) | 32'(k));
      repeat (8) begin
         @(posedge clk);
         seen = seen | coord_exec;
      end
      chk(seen, 1);
      // Move on a marked, manually moving axis waits, then errors
      wr(`MAS_OFF_CTRL, A | J);
      wr(`MAS_OFF_MAE, m);
      sync();
      wr(`MAS_OFF_MINUS, m);
      sync();
      wr(`MAS_OFF_CMD, (32'h1 << `MAS_CMD_MOVE) | 32'(k));
      seen = 1'b0;
      repeat (8) begin
         @(posedge clk);
         seen = seen | coord_exec;
      end
      wr(`MAS_OFF_MINUS, 0);
      sync();
      chk({seen, coord_exec, op_err}, 3'b001);
      $display("test command done");
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: sim/mas_ladder_model.sv */
// Sequence-program partner: scan strobe and APB master
`timescale 1ns/1ps
`default_nettype none
`include "mas_axis_map.svh"
module mas_ladder_model #(
   parameter int SCAN_PER = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] prdata_i,
   input wire logic pready_i,
   input wire logic pslverr_i,
   output logic scan_o,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [`MAS_ADDR_W-1:0] paddr_o,
   output logic [31:0] pwdata_o
);
   int cnt;
   initial begin
      scan_o = 1'b0;
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = '0;
      pwdata_o = '0;
   end
   // ------------------------------------------------------------
   // Scan strobe
   // ------------------------------------------------------------
   // One-cycle strobe, well over the two-cycle minimum spacing
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 0;
         scan_o <= 1'b0;
      end else begin
         cnt <= (cnt == SCAN_PER - 1) ? 0 : cnt + 1;
         scan_o <= (cnt == SCAN_PER - 1);
      end
   end
   // ------------------------------------------------------------
   // Register transfer
   // ------------------------------------------------------------
   // Axis masks travel whole, one word per register
   task automatic xfer(input logic wr, input logic [`MAS_ADDR_W-1:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic err);
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= wr;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      // Ready ends this wait; without it only the bench timeout does
      do begin
         @(posedge clk_i);
      end while (pready_i !== 1'b1);
      r = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // Released lines must not look held
      paddr_o <= ~a;
      pwdata_o <= ~d;
   endtask
endmodule
`default_nettype wire
